// >>> flow_ctl_defines.svh
`ifndef FLOW_CTL_DEFINES_SVH
`define FLOW_CTL_DEFINES_SVH

// ------------------------------------------------------------
// Characters
// ------------------------------------------------------------
`define PAUSE_CHAR        7'h13
`define RESUME_CHAR       7'h11

// ------------------------------------------------------------
// Register word addresses
// ------------------------------------------------------------
`define LINE_CTL_BASE     4'h0
`define GLOBAL_CTL_ADDR   4'h8
`define STATUS_ADDR       4'h9

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LC_RX_LEVEL_BIT   1
`define LC_TX_AUTO_BIT    4
`define LC_PAUSE_REQ_BIT  5
`define GC_SUPPRESS_BIT   0
`define GC_SOFT_RESET_BIT 1
`define ST_CRITICAL_BIT   8

// ------------------------------------------------------------
// Reset values and levels
// ------------------------------------------------------------
`define LINE_CTL_RESET    8'h00
`define ALLOW_RESET       8'hFF
`define CRIT_SET_LEVEL    9'h0C0
`define CRIT_CLEAR_LEVEL  9'h07F

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define DETECT_DELAY_US   350
`define DETECT_CYCLES     ((`DETECT_DELAY_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> flow_ctl_pkg.sv
package flow_ctl_pkg;

   typedef logic [7:0] chan_vec_t;
   typedef logic [7:0][7:0] line_ctl_arr_t;
   typedef logic [7:0][1:0] phase_arr_t;

   typedef struct packed {
      line_ctl_arr_t line_ctl;
      logic          suppress;
      chan_vec_t     allow;
      logic          crit;
      logic          crit_seen;
      chan_vec_t     rx_seen;
      chan_vec_t     level_paused;
      chan_vec_t     force_seen;
      chan_vec_t     extra_xoff;
      phase_arr_t    rx_phase;
      chan_vec_t     pend_xoff;
      chan_vec_t     pend_xon;
      logic [31:0]   tick_cnt;
      logic          ack;
      logic [31:0]   rdata;
      logic          tx_load;
      logic [2:0]    tx_chan;
      logic [7:0]    tx_char;
   } state_t;

endpackage : flow_ctl_pkg

// >>> xon_xoff_auto_flow_control.sv
`timescale 1ns/100ps
`include "flow_ctl_defines.svh"

// How it works
// - Pause is octal 023, resume octal 021, sent opposite the data flow.
// - Every channel has its own enable bit for each flow mode.
// - Received pause clears transmit_allow; data stops, generated codes still go.
// - Received resume sets transmit_allow again so data resumes.
// - Only error-free characters, parity bit stripped, are compared.
// - Transmit auto flow works only while line control bit 4 is set.
// - Flow characters enter the FIFO unless suppress_flow_char_report is set.
// - FIFO critical sends pause on enabled channels that supplied data.
// - Receive-level flow works only while line control bit 1 is set.
// - Disabling level flow after a pause still yields the matching resume.
// - Critical sets at 192 entries, clears at 127 entries.
// - Setting line control bit 5 sends pause on that channel.
// - While the request stays set, pause follows every second received char.
// - Clearing the request sends resume, when no other source holds pause.
// - Reset clears the software pause request on every channel.
// - Detection may lag up to 350 us; a short-lived cause sends nothing.
// - Both sources are ORed; resume only when both are inactive.
// - Setting the request sends pause even if level pause already sent.
// - Critical rising during the request sends pause on next received char.
module xon_xoff_auto_flow_control #(
   parameter int CHANNELS      = 8,
   parameter int DETECT_CYCLES = `DETECT_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_valid,
   input  wire logic [2:0]  rx_chan,
   input  wire logic [7:0]  rx_char,
   input  wire logic        rx_error,
   output logic             fifo_push,
   output logic      [2:0]  fifo_chan,
   output logic      [7:0]  fifo_char,
   input  wire logic [8:0]  fifo_level,
   input  wire logic [7:0]  tx_idle,
   input  wire logic [7:0]  data_pending,
   input  wire logic [63:0] data_char,
   output logic      [7:0]  data_take,
   output logic             tx_load,
   output logic      [2:0]  tx_chan,
   output logic      [7:0]  tx_char,
   output logic      [7:0]  transmit_allow,
   output logic             receive_fifo_critical
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (CHANNELS != 8)
   begin : g_chan_check
      $error("CHANNELS must be 8");
   end
   if (DETECT_CYCLES < 1)
   begin : g_tick_check
      $error("DETECT_CYCLES must be at least 1");
   end

   flow_ctl_pkg::state_t st_reg;
   flow_ctl_pkg::state_t st_next;

   logic       req;
   logic       rx_good;
   logic       rx_is_pause;
   logic       rx_is_resume;
   logic       tick;
   logic       tx_sel_found;
   logic [2:0] tx_sel;
   logic [7:0] tx_sel_char;
   logic [1:0] tx_sel_kind;

   assign req = avs_read | avs_write;
   // Answer one cycle after the request appears
   assign avs_waitrequest = req & ~st_reg.ack;
   assign avs_readdata = st_reg.rdata;
   assign transmit_allow = st_reg.allow;
   assign receive_fifo_critical = st_reg.crit;
   assign tx_load = st_reg.tx_load;
   assign tx_chan = st_reg.tx_chan;
   assign tx_char = st_reg.tx_char;

   // ------------------------------------------------------------
   // Receive classification
   // ------------------------------------------------------------
   assign rx_good = rx_valid & ~rx_error;
   assign rx_is_pause = rx_good & (rx_char[6:0] == `PAUSE_CHAR);
   assign rx_is_resume = rx_good & (rx_char[6:0] == `RESUME_CHAR);
   assign fifo_push = rx_valid
                      & ~(st_reg.suppress & (rx_is_pause | rx_is_resume));
   assign fifo_chan = rx_chan;
   assign fifo_char = rx_char;

   // Causes are sampled only on this tick, so a request that comes and
   // goes between two ticks never produces a pause.
   assign tick = (st_reg.tick_cnt == 32'(DETECT_CYCLES - 1));

   // ------------------------------------------------------------
   // Transmit selection: lowest idle channel with work wins
   // ------------------------------------------------------------
   always_comb
   begin
      tx_sel_found = 1'b0;
      tx_sel = 3'h0;
      tx_sel_char = 8'h00;
      tx_sel_kind = 2'h0;
      for (int c = 7; c >= 0; c--)
      begin
         if (tx_idle[c] & ~st_reg.tx_load)
         begin
            if (st_reg.pend_xoff[c])
            begin
               // Generated codes ignore transmit_allow
               tx_sel_found = 1'b1;
               tx_sel = 3'(c);
               tx_sel_char = {1'b0, `PAUSE_CHAR};
               tx_sel_kind = 2'h1;
            end
            else if (st_reg.pend_xon[c])
            begin
               tx_sel_found = 1'b1;
               tx_sel = 3'(c);
               tx_sel_char = {1'b0, `RESUME_CHAR};
               tx_sel_kind = 2'h2;
            end
            else if (data_pending[c]
                     & (st_reg.allow[c]
                        | ~st_reg.line_ctl[c][`LC_TX_AUTO_BIT]))
            begin
               tx_sel_found = 1'b1;
               tx_sel = 3'(c);
               tx_sel_char = data_char[c*8 +: 8];
               tx_sel_kind = 2'h3;
            end
         end
      end
   end

   always_comb
   begin
      data_take = 8'h00;
      if (tx_sel_found && tx_sel_kind == 2'h3)
      begin
         data_take[tx_sel] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic       crit_rise;
      logic       level_src;
      logic       was_paused;
      logic       now_paused;
      logic       rx_here;
      logic [3:0] idx;
      crit_rise = 1'b0;
      level_src = 1'b0;
      was_paused = 1'b0;
      now_paused = 1'b0;
      rx_here = 1'b0;
      idx = 4'h0;
      st_next = st_reg;

      // Register bus
      st_next.ack = req & ~st_reg.ack;
      if (req & ~st_reg.ack & avs_read)
      begin
         st_next.rdata = 32'h0000_0000;
         if (avs_address < `GLOBAL_CTL_ADDR)
         begin
            idx = avs_address - `LINE_CTL_BASE;
            st_next.rdata[7:0] = st_reg.line_ctl[idx[2:0]];
         end
         else if (avs_address == `GLOBAL_CTL_ADDR)
         begin
            st_next.rdata[`GC_SUPPRESS_BIT] = st_reg.suppress;
         end
         else if (avs_address == `STATUS_ADDR)
         begin
            st_next.rdata[7:0] = st_reg.allow;
            st_next.rdata[`ST_CRITICAL_BIT] = st_reg.crit;
         end
      end
      if (req & ~st_reg.ack & avs_write)
      begin
         if (avs_address < `GLOBAL_CTL_ADDR)
         begin
            idx = avs_address - `LINE_CTL_BASE;
            st_next.line_ctl[idx[2:0]] = avs_writedata[7:0];
         end
         else if (avs_address == `GLOBAL_CTL_ADDR)
         begin
            st_next.suppress = avs_writedata[`GC_SUPPRESS_BIT];
            if (avs_writedata[`GC_SOFT_RESET_BIT])
            begin
               for (int c = 0; c < 8; c++)
               begin
                  st_next.line_ctl[c][`LC_PAUSE_REQ_BIT] = 1'b0;
               end
            end
         end
      end

      // FIFO level with hysteresis
      if (fifo_level >= `CRIT_SET_LEVEL)
      begin
         st_next.crit = 1'b1;
      end
      else if (fifo_level <= `CRIT_CLEAR_LEVEL)
      begin
         st_next.crit = 1'b0;
      end

      st_next.tick_cnt = tick ? 32'h0000_0000 : st_reg.tick_cnt + 32'h1;
      if (tick)
      begin
         st_next.crit_seen = st_reg.crit;
      end
      crit_rise = tick & st_reg.crit & ~st_reg.crit_seen;

      st_next.tx_load = tx_sel_found;
      st_next.tx_chan = tx_sel;
      st_next.tx_char = tx_sel_char;

      for (int c = 0; c < 8; c++)
      begin
         rx_here = rx_good & (rx_chan == 3'(c));

         // Received flow characters steer the transmitter
         if (rx_here & st_reg.line_ctl[c][`LC_TX_AUTO_BIT])
         begin
            if (rx_is_pause)
            begin
               st_next.allow[c] = 1'b0;
            end
            else if (rx_is_resume)
            begin
               st_next.allow[c] = 1'b1;
            end
         end

         // Codes leave the pending set when launched
         if (tx_sel_found && tx_sel == 3'(c) && tx_sel_kind == 2'h1)
         begin
            st_next.pend_xoff[c] = 1'b0;
         end
         if (tx_sel_found && tx_sel == 3'(c) && tx_sel_kind == 2'h2)
         begin
            st_next.pend_xon[c] = 1'b0;
         end

         if (rx_here)
         begin
            st_next.rx_seen[c] = 1'b1;
         end
         if (tick & ~st_reg.crit)
         begin
            st_next.rx_seen[c] = rx_here;
         end

         // Level source: only channels that supplied data
         level_src = st_reg.crit & st_reg.rx_seen[c]
                     & st_reg.line_ctl[c][`LC_RX_LEVEL_BIT];
         was_paused = st_reg.level_paused[c] | st_reg.force_seen[c];
         if (tick & level_src & ~st_reg.level_paused[c])
         begin
            st_next.level_paused[c] = 1'b1;
            st_next.pend_xoff[c] = 1'b1;
         end
         // Held until critical clears even if the enable is dropped
         if (tick & ~st_reg.crit)
         begin
            st_next.level_paused[c] = 1'b0;
         end

         // Software source
         if (tick)
         begin
            st_next.force_seen[c] = st_reg.line_ctl[c][`LC_PAUSE_REQ_BIT];
            if (st_reg.line_ctl[c][`LC_PAUSE_REQ_BIT]
                & ~st_reg.force_seen[c])
            begin
               st_next.pend_xoff[c] = 1'b1;
               st_next.rx_phase[c] = 2'h0;
            end
            if (crit_rise & st_reg.force_seen[c])
            begin
               st_next.extra_xoff[c] = 1'b1;
            end
         end
         if (rx_here & st_reg.force_seen[c])
         begin
            if (st_reg.rx_phase[c] == 2'h1 | st_reg.extra_xoff[c])
            begin
               st_next.pend_xoff[c] = 1'b1;
               st_next.extra_xoff[c] = 1'b0;
            end
            st_next.rx_phase[c] = (st_reg.rx_phase[c] == 2'h1)
                                  ? 2'h0 : 2'h1;
         end

         // Combined source decides resume
         now_paused = st_next.level_paused[c] | st_next.force_seen[c];
         if (was_paused & ~now_paused)
         begin
            st_next.pend_xon[c] = 1'b1;
            st_next.pend_xoff[c] = 1'b0;
            st_next.extra_xoff[c] = 1'b0;
         end
         if (now_paused)
         begin
            st_next.pend_xon[c] = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         // Line control reset clears every enable and pause request
         st_reg.line_ctl <= {8{`LINE_CTL_RESET}};
         st_reg.allow <= `ALLOW_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

endmodule : xon_xoff_auto_flow_control

// >>> xon_xoff_auto_flow_control_asserts.sv
`timescale 1ns/100ps
`include "flow_ctl_defines.svh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module flow_ctl_checker (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        rx_valid,
   input wire logic [2:0]  rx_chan,
   input wire logic [7:0]  rx_char,
   input wire logic        rx_error,
   input wire logic        fifo_push,
   input wire logic [8:0]  fifo_level,
   input wire logic [7:0]  data_take,
   input wire logic        tx_load,
   input wire logic [7:0]  transmit_allow,
   input wire logic        receive_fifo_critical
);
   logic [7:0] auto_reg;
   logic       supp_reg;
   logic       good;
   logic       flow;
   logic       wr;
   assign wr   = avs_write && !avs_waitrequest;
   assign good = rx_valid && !rx_error;
   assign flow = rx_char[6:0] == `PAUSE_CHAR || rx_char[6:0] == `RESUME_CHAR;
   // Shadow of the enables, since the checker cannot see the registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         auto_reg <= 8'h00;
         supp_reg <= 1'b0;
      end
      else
      begin
         if (wr && avs_address < 4'h8)
            auto_reg[avs_address[2:0]] <= avs_writedata[`LC_TX_AUTO_BIT];
         if (wr && avs_address == `GLOBAL_CTL_ADDR)
            supp_reg <= avs_writedata[`GC_SUPPRESS_BIT];
      end
   end
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_pause; good && rx_char[6:0] == `PAUSE_CHAR && auto_reg[rx_chan]
      |=> !transmit_allow[$past(rx_chan)]; endproperty
   a_pause: assert property (p_pause) else $error("pause ignored");
   property p_resume; good && rx_char[6:0] == `RESUME_CHAR && auto_reg[rx_chan]
      |=> transmit_allow[$past(rx_chan)]; endproperty
   a_resume: assert property (p_resume) else $error("resume ignored");
   property p_bad; rx_valid && rx_error |=> $stable(transmit_allow); endproperty
   a_bad: assert property (p_bad) else $error("errored char acted on");
   property p_off; rx_valid && !auto_reg[rx_chan] |=> $stable(transmit_allow); endproperty
   a_off: assert property (p_off) else $error("allow moved while off");
   property p_push; fifo_push == (rx_valid && !(supp_reg && good && flow)); endproperty
   a_push: assert property (p_push) else $error("fifo push wrong");
   property p_set; fifo_level >= 9'h0C0 |=> receive_fifo_critical; endproperty
   a_set: assert property (p_set) else $error("critical not set");
   property p_clr; fifo_level <= 9'h07F |=> !receive_fifo_critical; endproperty
   a_clr: assert property (p_clr) else $error("critical not cleared");
   property p_hold; fifo_level > 9'h07F && fifo_level < 9'h0C0
      |=> $stable(receive_fifo_critical); endproperty
   a_hold: assert property (p_hold) else $error("critical changed in band");
   property p_gate; (data_take & auto_reg & ~transmit_allow) == 8'h00; endproperty
   a_gate: assert property (p_gate) else $error("data sent while paused");
   property p_space; tx_load |=> !tx_load; endproperty
   a_space: assert property (p_space) else $error("loads too close");
endmodule : flow_ctl_checker

bind xon_xoff_auto_flow_control flow_ctl_checker u_chk (.sys_clk, .rst_n,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
   .rx_valid, .rx_chan, .rx_char, .rx_error, .fifo_push, .fifo_level,
   .data_take, .tx_load, .transmit_allow, .receive_fifo_critical);

// >>> remote_terminal.sv
`timescale 1ns/100ps
`include "flow_ctl_defines.svh"
// ------------------------------------------------------------
// Remote terminal on each line
// ------------------------------------------------------------
module remote_terminal #(
   parameter int CHAR_CYCLES = 6
) (
   input  wire logic       sys_clk,
   input  wire logic       tx_load,
   input  wire logic [2:0] tx_chan,
   input  wire logic [7:0] tx_char,
   output logic      [7:0] tx_idle,
   output logic      [7:0] stopped
);
   int busy [8] = '{default: 0};
   initial stopped = 8'h00;
   // A loaded line stays busy for a whole character time
   always @(posedge sys_clk)
   begin
      for (int c = 0; c < 8; c++)
      begin
         if (busy[c] > 0)
            busy[c] <= busy[c] - 1;
      end
      if (tx_load)
      begin
         busy[tx_chan] <= CHAR_CYCLES;
         if (tx_char[6:0] == `PAUSE_CHAR)
            stopped[tx_chan] <= 1'b1;
         if (tx_char[6:0] == `RESUME_CHAR)
            stopped[tx_chan] <= 1'b0;
      end
   end
   always_comb
   begin
      for (int c = 0; c < 8; c++)
         tx_idle[c] = busy[c] == 0;
   end
endmodule : remote_terminal

// >>> xon_xoff_auto_flow_control_bench.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module xon_xoff_auto_flow_control_bench;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        rx_valid = 1'b0;
   logic [2:0]  rx_chan = 3'h0;
   logic [7:0]  rx_char = 8'h00;
   logic        rx_error = 1'b0;
   logic [8:0]  fifo_level = 9'h000;
   logic [7:0]  data_pending = 8'h00;
   logic [63:0] data_char = 64'h0;
   logic [31:0] avs_readdata, rd;
   logic [7:0]  tx_idle, data_take, transmit_allow, stopped, tx_char;
   logic [2:0]  tx_chan;
   logic        avs_waitrequest, fifo_push, tx_load, crit;
   int          failures = 0;
   int          n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   xon_xoff_auto_flow_control #(.DETECT_CYCLES(8)) DUT (.sys_clk, .rst_n,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .rx_valid, .rx_chan, .rx_char, .rx_error,
      .fifo_push, .fifo_chan(), .fifo_char(), .fifo_level, .tx_idle,
      .data_pending, .data_char, .data_take, .tx_load, .tx_chan, .tx_char,
      .transmit_allow, .receive_fifo_critical(crit));
   remote_terminal #(.CHAR_CYCLES(6)) u_term (.sys_clk, .tx_load, .tx_chan,
      .tx_char, .tx_idle, .stopped);
   task automatic final_report;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_up;
      failures++;
      final_report();
   endtask : give_up
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // Look at the answer mid-cycle, where it is settled, and let the
      // accepting edge pass before the request is released
      for (n = 0; n < 50; n++)
      begin
         @(negedge sys_clk);
         if (!avs_waitrequest)
         begin
            rd = avs_readdata;
            @(posedge sys_clk);
            break;
         end
         @(posedge sys_clk);
      end
      if (n == 50)
         give_up();
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   task automatic rx(input logic [2:0] c, input logic [7:0] ch,
                     input logic err, input logic push);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_chan <= c;
      rx_char <= ch;
      rx_error <= err;
      @(negedge sys_clk);
      check(fifo_push, push);
      @(posedge sys_clk);
      rx_valid <= 1'b0;
   endtask : rx
   task automatic wait_tx(input logic [2:0] c, input logic [7:0] ch);
      int n;
      for (n = 0; n < 400; n++)
      begin
         @(negedge sys_clk);
         if (tx_load && tx_chan == c)
            break;
      end
      if (n == 400)
         give_up();
      check(tx_char, ch);
   endtask : wait_tx
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 8; c++)
         rdchk(c[3:0], 32'h0);
      rdchk(4'h9, 32'hFF);
      rdchk(4'hC, 32'h0);
      // Transmit side: ch0 off, ch2 and ch3 under automatic control
      bus(1'b1, 4'h2, 32'h10);
      bus(1'b1, 4'h3, 32'h10);
      rx(3'h0, 8'h13, 1'b0, 1'b1);
      rx(3'h2, 8'h13, 1'b0, 1'b1);
      rx(3'h3, 8'h93, 1'b0, 1'b1);
      rx(3'h3, 8'h11, 1'b1, 1'b1);
      rdchk(4'h9, 32'hF3);
      data_pending <= 8'h04;
      data_char[23:16] <= 8'h41;
      repeat (30) @(posedge sys_clk);
      rx(3'h2, 8'h11, 1'b0, 1'b1);
      wait_tx(3'h2, 8'h41);
      @(posedge sys_clk);
      data_pending <= 8'h00;
      // Flow characters kept out of the FIFO while suppressed
      bus(1'b1, 4'h8, 32'h1);
      rx(3'h3, 8'h11, 1'b0, 1'b0);
      rx(3'h3, 8'h41, 1'b0, 1'b1);
      bus(1'b1, 4'h8, 32'h0);
      rdchk(4'h9, 32'hFF);
      // Software pause request on ch1
      bus(1'b1, 4'h1, 32'h20);
      wait_tx(3'h1, 8'h13);
      @(negedge sys_clk);
      check(stopped, 8'h02);
      rx(3'h1, 8'h61, 1'b0, 1'b1);
      rx(3'h1, 8'h62, 1'b0, 1'b1);
      wait_tx(3'h1, 8'h13);
      bus(1'b1, 4'h1, 32'h0);
      wait_tx(3'h1, 8'h11);
      // FIFO level pause on ch4 and ch5, ch5 disabled before the drain
      bus(1'b1, 4'h4, 32'h2);
      bus(1'b1, 4'h5, 32'h2);
      // Critical first: a tick while it is clear forgets earlier senders
      fifo_level <= 9'h0C0;
      rx(3'h4, 8'h30, 1'b0, 1'b1);
      rx(3'h5, 8'h31, 1'b0, 1'b1);
      wait_tx(3'h4, 8'h13);
      wait_tx(3'h5, 8'h13);
      rdchk(4'h9, 32'h1FF);
      bus(1'b1, 4'h5, 32'h0);
      fifo_level <= 9'h0A0;
      repeat (30) @(posedge sys_clk);
      rdchk(4'h9, 32'h1FF);
      fifo_level <= 9'h07F;
      wait_tx(3'h4, 8'h11);
      wait_tx(3'h5, 8'h11);
      // Global soft reset clears a pending software pause request
      bus(1'b1, 4'h1, 32'h20);
      bus(1'b1, 4'h8, 32'h2);
      rdchk(4'h1, 32'h0);
      final_report();
   end
endmodule : xon_xoff_auto_flow_control_bench
